/* File: core/pisr_resolver.sv */
// Package idle state resolver with its register slave.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pisr_resolver
    import pisr_pkg::*;
#(
    parameter int NCORE       = 2,
    parameter int NTHR        = 2,
    parameter int NWAYS       = 16,
    parameter int WAYS_STEP   = 2,
    parameter int STEP_CYC    = FLUSH_STEP_CYC,
    parameter int PROMO_CYC   = PROMOTE_CYC
) (
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire logic                       clk_en,
    input  wire pisr_cs_t [NCORE-1:0][NTHR-1:0] thread_req,
    input  wire logic [NCORE-1:0]           c1e_hint,
    input  wire logic [NCORE-1:0]           halt_c1,
    input  wire logic                       gfx_deep,
    input  wire logic                       latency_block,
    input  wire logic                       flush_all_hint,
    input  wire pisr_cs_t                   pf_grant,
    input  wire pisr_brk_s                  brk_in,
    input  wire logic [NCORE-1:0]           brk_core_sel,
    input  wire pisr_axi_req_s              axi_req,
    output pisr_axi_rsp_s                   axi_rsp,
    output pisr_state_e                     pkg_state,
    output pisr_cs_t                        pkg_req,
    output logic [NCORE-1:0]                core_wake,
    output logic                            brk_fwd,
    output logic                            brk_fwd_masked,
    output logic                            freq_low,
    output logic                            volt_low,
    output logic                            llc_flush,
    output logic [WAYS_W-1:0]               llc_ways,
    output logic                            sa_power_off
);
    localparam int RC_W = $clog2(PROMO_CYC + 1);
    localparam int SC_W = $clog2(STEP_CYC + 1);
    localparam logic [WAYS_W-1:0] WAYS_MAX = WAYS_W'(NWAYS);
    localparam logic [WAYS_W-1:0] WAYS_DEC = WAYS_W'(WAYS_STEP);
    localparam logic [RC_W-1:0] RC_TOP = RC_W'(PROMO_CYC);
    localparam logic [SC_W-1:0] SC_TOP = SC_W'(STEP_CYC - 1);

    pisr_cs_t [NCORE-1:0] core_cs;
    logic [NCORE-1:0]     core_is_c6;
    pisr_cs_t             pkg_req_c;
    pisr_cs_t             eff_c;
    pisr_state_e          tgt_c;
    pisr_state_e          state_reg;
    pisr_state_e          prev_reg;
    logic                 mem_svc_reg;
    logic                 c1e_ok;
    logic                 low_power;
    logic                 deep_state;
    logic                 flush_ok;
    logic [RC_W-1:0]      res_cnt_reg;
    logic [SC_W-1:0]      step_cnt_reg;
    logic [CTL_W-1:0]     ctrl_reg;
    pisr_cs_t             pkg_req_reg;
    logic [NCORE-1:0]     core_wake_reg;
    logic                 brk_fwd_reg;
    logic                 brk_masked_reg;
    logic                 freq_low_reg;
    logic                 volt_low_reg;
    logic                 llc_flush_reg;
    logic [WAYS_W-1:0]    ways_reg;
    logic                 sa_off_reg;

    function automatic pisr_cs_t st_code(input pisr_state_e s);
        case (s)
            ST_C1, ST_C1E: st_code = CS_C1;
            ST_C2:         st_code = CS_C2;
            ST_C3:         st_code = CS_C3;
            ST_C6:         st_code = CS_C6;
            ST_C7:         st_code = CS_C7;
            default:       st_code = CS_C0;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NCORE; gi++) begin : g_core
            always_comb begin
                core_cs[gi] = thread_req[gi][0];
                for (int t = 1; t < NTHR; t++) begin
                    if (thread_req[gi][t] < core_cs[gi]) begin
                        core_cs[gi] = thread_req[gi][t];
                    end
                end
            end
            assign core_is_c6[gi] = (core_cs[gi] == CS_C6);
        end
    endgenerate

    always_comb begin
        pkg_req_c = core_cs[0];
        for (int c = 1; c < NCORE; c++) begin
            if (core_cs[c] < pkg_req_c) begin
                pkg_req_c = core_cs[c];
            end
        end
    end

    // The residency heuristic only promotes a settled C3 package to C6, and
    // still never past what the platform grants.
    always_comb begin
        eff_c = (pf_grant < pkg_req_c) ? pf_grant : pkg_req_c;
        if (ctrl_reg[CTL_DEEPEN] && pkg_req_c == CS_C3 &&
            res_cnt_reg == RC_TOP) begin
            eff_c = (pf_grant < CS_C6) ? pf_grant : CS_C6;
        end
    end

    assign c1e_ok = ctrl_reg[CTL_C1E_EN] &&
                    ((&c1e_hint) || ((&halt_c1) && ctrl_reg[CTL_AUTOPRO]) ||
                     ctrl_reg[CTL_LIMIT_C1]);

    always_comb begin
        if (pkg_req_c == CS_C0 || eff_c == CS_C0) begin
            tgt_c = ST_C0;
        end else if (pkg_req_c == CS_C1 || eff_c == CS_C1 ||
                     ctrl_reg[CTL_LIMIT_C1]) begin
            tgt_c = c1e_ok ? ST_C1E : ST_C1;
        end else if (!gfx_deep || latency_block || eff_c == CS_C2) begin
            tgt_c = ST_C2;
        end else if (eff_c < CS_C6) begin
            tgt_c = ST_C3;
        end else if (eff_c == CS_C6) begin
            tgt_c = ST_C6;
        end else begin
            tgt_c = ST_C7;
        end
    end

    assign low_power  = (state_reg != ST_C0) && (state_reg != ST_WAKE);
    assign deep_state = (state_reg == ST_C3) || (state_reg == ST_C6) ||
                        (state_reg == ST_C7);

    // Entering C1 raises no event anywhere and C1E only drives freq_low and volt_low;
    // software sees either only by polling the status word.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_C0;
            prev_reg    <= ST_C0;
            mem_svc_reg <= 1'b0;
        end else if (clk_en) begin
            if (brk_in.core_brk && low_power) begin
                prev_reg  <= state_reg;
                state_reg <= brk_in.core_masked ? ST_WAKE : ST_C0;
                // A break ends any memory service, so that its later return
                // cannot send a woken package back into C2.
                mem_svc_reg <= 1'b0;
            end else if (brk_in.mem_req && deep_state) begin
                prev_reg    <= state_reg;
                state_reg   <= ST_C2;
                mem_svc_reg <= 1'b1;
            end else if (mem_svc_reg) begin
                if (!brk_in.mem_busy) begin
                    mem_svc_reg <= 1'b0;
                    if (pf_grant < st_code(prev_reg)) begin
                        state_reg <= tgt_c;
                    end else begin
                        state_reg <= prev_reg;
                    end
                end
            end else if (state_reg == ST_WAKE) begin
                state_reg <= prev_reg;
            end else begin
                state_reg <= tgt_c;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            res_cnt_reg <= '0;
        end else if (clk_en) begin
            if (state_reg != ST_C3 && state_reg != ST_C6) begin
                res_cnt_reg <= '0;
            end else if (res_cnt_reg != RC_TOP) begin
                res_cnt_reg <= res_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_wake_reg  <= '0;
            brk_fwd_reg    <= 1'b0;
            brk_masked_reg <= 1'b0;
            pkg_req_reg    <= CS_C0;
        end else if (clk_en) begin
            pkg_req_reg    <= pkg_req_c;
            brk_fwd_reg    <= brk_in.core_brk && low_power;
            brk_masked_reg <= brk_in.core_masked;
            core_wake_reg  <= (brk_in.core_brk && low_power) ?
                              brk_core_sel : '0;
        end
    end

    // Voltage only follows once the clock already sits at its floor, so the
    // rail never drops under a fast clock.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_low_reg <= 1'b0;
            volt_low_reg <= 1'b0;
        end else if (clk_en) begin
            freq_low_reg <= (state_reg == ST_C1E);
            volt_low_reg <= (state_reg == ST_C1E) && freq_low_reg;
        end
    end

    assign flush_ok = ctrl_reg[CTL_FLUSH_EN] && !(|core_is_c6) &&
                      pkg_req_c == CS_C7 &&
                      (state_reg == ST_C6 || state_reg == ST_C7);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_cnt_reg <= '0;
            ways_reg     <= WAYS_MAX;
            llc_flush_reg <= 1'b0;
            sa_off_reg   <= 1'b0;
        end else if (clk_en) begin
            step_cnt_reg  <= (step_cnt_reg == SC_TOP) ? '0 :
                             step_cnt_reg + 1'b1;
            llc_flush_reg <= flush_ok && ways_reg != '0;
            sa_off_reg    <= (state_reg == ST_C7);
            if (flush_ok) begin
                if (flush_all_hint) begin
                    ways_reg <= '0;
                end else if (step_cnt_reg == SC_TOP) begin
                    ways_reg <= (ways_reg > WAYS_DEC) ?
                                ways_reg - WAYS_DEC : '0;
                end
            end else if (state_reg == ST_C0 && ways_reg != WAYS_MAX &&
                         step_cnt_reg == SC_TOP) begin
                ways_reg <= ways_reg + 1'b1;
            end
        end
    end

    // Register slave. Address and data are caught separately in either order
    // and the write completes once both are held.
    logic                 aw_got_reg;
    logic                 w_got_reg;
    logic [AXI_AW-1:0]    aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 arready_reg;
    logic                 rvalid_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;
    logic                 aw_hs;
    logic                 w_hs;
    logic                 wr_fire;
    logic                 ar_hs;
    logic                 aw_got_next;
    logic                 w_got_next;
    logic [31:0]          status_c;

    assign aw_hs   = axi_req.awvalid && awready_reg;
    assign w_hs    = axi_req.wvalid && wready_reg;
    assign ar_hs   = axi_req.arvalid && arready_reg;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign aw_got_next = aw_hs || (aw_got_reg && !wr_fire);
    assign w_got_next  = w_hs || (w_got_reg && !wr_fire);

    always_comb begin
        status_c = '0;
        status_c[STS_STATE_LSB +: 3]      = state_reg;
        status_c[STS_REQ_LSB +: CS_W]     = pkg_req_reg;
        status_c[STS_WAYS_LSB +: WAYS_W]  = ways_reg;
        status_c[STS_SA_BIT]              = sa_off_reg;
        status_c[STS_FLUSH_BIT]           = llc_flush_reg;
        status_c[STS_C1E_BIT]             = volt_low_reg;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            ctrl_reg    <= CTL_RST;
        end else if (clk_en) begin
            aw_got_reg  <= aw_got_next;
            w_got_reg   <= w_got_next;
            awready_reg <= !aw_got_next;
            wready_reg  <= !w_got_next;
            if (aw_hs) begin
                aw_addr_reg <= axi_req.awaddr;
            end
            if (w_hs) begin
                w_data_reg <= axi_req.wdata;
                w_strb_reg <= axi_req.wstrb;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                if (aw_addr_reg == OFS_CTRL) begin
                    bresp_reg <= RESP_OKAY;
                    if (w_strb_reg[0]) begin
                        ctrl_reg <= w_data_reg[CTL_W-1:0];
                    end
                end else if (aw_addr_reg == OFS_STATUS) begin
                    bresp_reg <= RESP_OKAY;
                end else begin
                    bresp_reg <= RESP_SLVERR;
                end
            end else if (bvalid_reg && axi_req.bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_hs) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= RESP_OKAY;
                if (axi_req.araddr == OFS_CTRL) begin
                    rdata_reg <= {{(32 - CTL_W){1'b0}}, ctrl_reg};
                end else if (axi_req.araddr == OFS_STATUS) begin
                    rdata_reg <= status_c;
                end else begin
                    rdata_reg <= '0;
                    rresp_reg <= RESP_SLVERR;
                end
            end else if (rvalid_reg && axi_req.rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end else if (!rvalid_reg) begin
                arready_reg <= 1'b1;
            end
        end
    end

    assign axi_rsp = {awready_reg, wready_reg, bvalid_reg, bresp_reg,
                      arready_reg, rvalid_reg, rdata_reg, rresp_reg};

    assign pkg_state      = state_reg;
    assign pkg_req        = pkg_req_reg;
    assign core_wake      = core_wake_reg;
    assign brk_fwd        = brk_fwd_reg;
    assign brk_fwd_masked = brk_masked_reg;
    assign freq_low       = freq_low_reg;
    assign volt_low       = volt_low_reg;
    assign llc_flush      = llc_flush_reg;
    assign llc_ways       = ways_reg;
    assign sa_power_off   = sa_off_reg;

    property p_req_min;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && core_cs[0] == CS_C0 |=> pkg_req_reg == CS_C0;
    endproperty
    a_req_min: assert property (p_req_min)
        else $error("package request not the lowest core state");

    property p_no_grant;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && pf_grant == CS_C0 && !brk_in.core_brk &&
        !brk_in.mem_req && !mem_svc_reg && state_reg != ST_WAKE
        |=> state_reg == ST_C0;
    endproperty
    a_no_grant: assert property (p_no_grant)
        else $error("package left active state without grant");

    property p_wake;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && brk_in.core_brk && low_power
        |=> brk_fwd_reg && core_wake_reg == $past(brk_core_sel);
    endproperty
    a_wake: assert property (p_wake)
        else $error("core break not forwarded to target core");

    property p_unmasked;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && brk_in.core_brk && !brk_in.core_masked && low_power
        |=> state_reg == ST_C0;
    endproperty
    a_unmasked: assert property (p_unmasked)
        else $error("unmasked break did not reach active state");

    property p_masked;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && brk_in.core_brk && brk_in.core_masked && low_power
        |=> state_reg == ST_WAKE && prev_reg == $past(state_reg);
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked break lost the previous state");

    property p_mem;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && brk_in.mem_req && !brk_in.core_brk && deep_state
        |=> state_reg == ST_C2 && mem_svc_reg;
    endproperty
    a_mem: assert property (p_mem)
        else $error("memory access did not move package to C2");

    property p_c1e_order;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(volt_low_reg) |-> freq_low_reg && $past(freq_low_reg);
    endproperty
    a_c1e_order: assert property (p_c1e_order)
        else $error("voltage lowered before clock reached floor");

    property p_no_flush_c6;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && (|core_is_c6) |=> !llc_flush_reg;
    endproperty
    a_no_flush_c6: assert property (p_no_flush_c6)
        else $error("cache flushed while a core requests C6");

    property p_c3_valid;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && state_reg == ST_C3 |=> !llc_flush_reg;
    endproperty
    a_c3_valid: assert property (p_c3_valid)
        else $error("cache flushed in package C3");

    property p_sa_off;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && state_reg == ST_C7 |=> sa_off_reg;
    endproperty
    a_sa_off: assert property (p_sa_off)
        else $error("system agent not powered off in C7");
endmodule

/* File: inc/pisr_pkg.sv */
// Shared constants and types of the package idle state resolver.
package pisr_pkg;
    localparam int CS_W = 3;
    typedef logic [CS_W-1:0] pisr_cs_t;
    localparam pisr_cs_t CS_C0 = 3'h0;
    localparam pisr_cs_t CS_C1 = 3'h1;
    localparam pisr_cs_t CS_C2 = 3'h2;
    localparam pisr_cs_t CS_C3 = 3'h3;
    localparam pisr_cs_t CS_C6 = 3'h6;
    localparam pisr_cs_t CS_C7 = 3'h7;

    typedef enum logic [2:0] {
        ST_C0   = 3'h0,
        ST_C1   = 3'h1,
        ST_C1E  = 3'h3,
        ST_C2   = 3'h2,
        ST_C3   = 3'h6,
        ST_C6   = 3'h7,
        ST_C7   = 3'h5,
        ST_WAKE = 3'h4
    } pisr_state_e;

    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] OFS_CTRL   = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CTL_W        = 8;
    localparam int CTL_C1E_EN   = 0;
    localparam int CTL_AUTOPRO  = 1;
    localparam int CTL_LIMIT_C1 = 2;
    localparam int CTL_DEEPEN   = 3;
    localparam int CTL_FLUSH_EN = 4;
    localparam logic [CTL_W-1:0] CTL_RST = 8'h11;

    localparam int STS_STATE_LSB = 0;
    localparam int STS_REQ_LSB   = 4;
    localparam int STS_WAYS_LSB  = 8;
    localparam int STS_SA_BIT    = 16;
    localparam int STS_FLUSH_BIT = 17;
    localparam int STS_C1E_BIT   = 18;

    localparam int WAYS_W = 8;
    localparam int CLK_NS = 10;
    localparam int FLUSH_STEP_NS = 100;
    localparam int FLUSH_STEP_CYC = (FLUSH_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROMOTE_NS = 2000;
    localparam int PROMOTE_CYC = (PROMOTE_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic              core_brk;
        logic              core_masked;
        logic              mem_req;
        logic              mem_busy;
    } pisr_brk_s;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } pisr_axi_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } pisr_axi_rsp_s;
endpackage

/* File: testbench/pisr_platform.sv */
// Platform controller model that grants the state given on limit, one cycle later.
`timescale 1ns/1ps
module pisr_platform
    import pisr_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     arst_n,
    input  wire pisr_cs_t limit,
    output pisr_cs_t      pf_grant
);
    // No permission during reset, so the package must start out active.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            pf_grant <= CS_C0;
        else
            pf_grant <= limit;
    end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the package idle state resolver.
`timescale 1ns/1ps
module tb_top
    import pisr_pkg::*;
;
    logic                sys_clk, arst_n, clk_en, gfx_deep, latency_block;
    logic                flush_all_hint, brk_fwd, brk_fwd_masked, bad;
    logic                freq_low, volt_low, llc_flush, sa_power_off;
    logic [1:0]          c1e_hint, halt_c1, brk_core_sel, core_wake;
    logic [7:0]          llc_ways;
    logic [31:0]         r;
    logic [33:0]         q[$];
    pisr_cs_t [1:0][1:0] thread_req;
    pisr_cs_t            pf_grant, pkg_req, lim, c, m;
    pisr_brk_s           brk_in;
    pisr_axi_req_s       axi_req;
    pisr_axi_rsp_s       axi_rsp;
    pisr_state_e         pkg_state;
    int                  n_fail, n_compared, cyc;
    pisr_cs_t            codes[8] = '{CS_C0, CS_C1, CS_C7, CS_C3,
                                      CS_C6, CS_C7, CS_C1, CS_C3};
    pisr_resolver #(.STEP_CYC(2), .PROMO_CYC(4)) dut (
        .sys_clk, .arst_n, .clk_en, .thread_req, .c1e_hint, .halt_c1,
        .gfx_deep, .latency_block, .flush_all_hint, .pf_grant, .brk_in,
        .brk_core_sel, .axi_req, .axi_rsp, .pkg_state, .pkg_req, .core_wake,
        .brk_fwd, .brk_fwd_masked, .freq_low, .volt_low, .llc_flush,
        .llc_ways, .sa_power_off
    );
    pisr_platform plat (.sys_clk, .arst_n, .limit(lim), .pf_grant);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input logic [33:0] g, input logic [33:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task complete_run;
        n_fail += q.size();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait; a visit to the active state is remembered in bad.
    task ws(input pisr_state_e s);
        for (int i = 0; i < 40 && pkg_state !== s; i++) begin
            @(posedge sys_clk);
            #1;
            if (pkg_state === ST_C0)
                bad = 1'b1;
        end
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        @(posedge sys_clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        do @(posedge sys_clk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        axi_req.rready <= 1'b1;
        do @(posedge sys_clk); while (!axi_rsp.rvalid);
        axi_req.rready <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge sys_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge sys_clk);
            if (axi_rsp.awready && !ta) begin
                ta = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (axi_rsp.wready && !tw) begin
                tw = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        while (!axi_rsp.bvalid) @(posedge sys_clk);
        axi_req.bready <= 1'b0;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    always @(posedge sys_clk)
        if (axi_rsp.rvalid && axi_req.rready)
            chk({axi_rsp.rresp, axi_rsp.rdata}, q.pop_front());
    initial begin
        {arst_n, gfx_deep, latency_block, flush_all_hint} = 4'h4;
        {c1e_hint, halt_c1, brk_core_sel, thread_req} = '0;
        {brk_in, axi_req, n_fail, n_compared, cyc} = '0;
        {clk_en, lim, r} = {1'b1, CS_C0, 32'h0001_6aa7};
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0011});
        rd(8'h0c, {RESP_SLVERR, 32'h0000_0000});
        repeat (8) begin
            r = lfsr(r);
            m = CS_C7;
            @(posedge sys_clk);
            for (int i = 0; i < 4; i++) begin
                c = codes[r[3*i+:3]];
                thread_req[i/2][i%2] <= c;
                m = (c < m) ? c : m;
            end
            {c1e_hint, halt_c1, flush_all_hint} <= r[16:12];
            repeat (2) @(posedge sys_clk);
            #1 chk(pkg_req, m);
            chk(pkg_state, ST_C0);
        end
        @(posedge sys_clk);
        thread_req <= {4{CS_C3}};
        lim <= CS_C3;
        ws(ST_C3);
        chk(pkg_state, ST_C3);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            brk_in.core_brk <= 1'b1;
            brk_in.core_masked <= k[0];
            brk_core_sel <= 2'b01;
            @(posedge sys_clk);
            brk_in <= '0;
            #1 chk({core_wake, brk_fwd, brk_fwd_masked},
                   {3'h3, k[0]});
            chk(pkg_state, k ? ST_WAKE : ST_C0);
            ws(ST_C3);
            chk(pkg_state, ST_C3);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            brk_in.mem_req <= 1'b1;
            brk_in.mem_busy <= 1'b1;
            @(posedge sys_clk);
            brk_in.mem_req <= 1'b0;
            lim <= k ? CS_C2 : CS_C3;
            #1 chk(pkg_state, ST_C2);
            @(posedge sys_clk);
            brk_in.mem_busy <= 1'b0;
            @(posedge sys_clk);
            #1 chk(pkg_state, k ? ST_C2 : ST_C3);
        end
        @(posedge sys_clk);
        lim <= CS_C3;
        wr(OFS_CTRL, 32'h0000_0015);
        bad = 1'b0;
        ws(ST_C1E);
        chk({pkg_state, bad}, {ST_C1E, 1'b0});
        chk({freq_low, volt_low}, 2'b10);
        @(posedge sys_clk);
        #1 chk({freq_low, volt_low}, 2'b11);
        @(posedge sys_clk);
        #1 chk({freq_low, volt_low}, 2'b11);
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0015});
        rd(OFS_STATUS, {RESP_OKAY, 32'h0004_1033});
        @(posedge sys_clk);
        {thread_req, lim, flush_all_hint} <= {{4{CS_C7}}, CS_C7, 1'b1};
        wr(OFS_CTRL, 32'h0000_0010);
        ws(ST_C7);
        chk({pkg_state, sa_power_off, llc_flush, llc_ways},
            {ST_C7, 10'h300});
        @(posedge sys_clk);
        #1 chk({sa_power_off, llc_flush, llc_ways}, 10'h200);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        thread_req <= '0;
        repeat (3) @(posedge sys_clk);
        #1 chk({pkg_state, sa_power_off}, {ST_C7, 1'b1});
        complete_run();
    end
endmodule
